// File: pkg/sync_serial_receiver_regs.svh
// constants for the synchronous serial receive path
// assumes a 50 MHz system clock; included by its bare name
`ifndef SYNC_SERIAL_RECEIVER_REGS_SVH
`define SYNC_SERIAL_RECEIVER_REGS_SVH

// =============================================================
// character layout
`define SSR_LOW_BITS 8
`define SSR_NINE_BITS 9
`define SSR_NINTH_POS 8

// =============================================================
// receive fifo
`define SSR_FIFO_DEPTH 2

// =============================================================
// master clock generation
`define SSR_SYS_CLK_HZ 50000000
`define SSR_HALF_PERIOD_NS 200
`define SSR_HALF_CYCLES ((`SSR_HALF_PERIOD_NS * (`SSR_SYS_CLK_HZ / 1000000)) / 1000)

// =============================================================
// reset values
`define SSR_CHAR_RESET 9'h000

`endif

// File: pkg/sync_serial_receiver_pkg.sv
// types shared by the synchronous serial receive path
// assumes the constants header is on the include path
`include "sync_serial_receiver_regs.svh"

package sync_serial_receiver_pkg;

    // one received character, ninth bit on top
    typedef struct packed {
        logic ninth;
        logic [`SSR_LOW_BITS-1:0] low;
    } rx_char_t;

    // master clock generator
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HIGH,
        ST_LOW
    } master_state_t;

endpackage

// File: hdl/link_shifter.sv
// slave-side shifter clocked by the externally supplied serial clock
// assumes the clock idles low, data valid at the falling edge
`timescale 1ns/1ps

module link_shifter
    import sync_serial_receiver_pkg::*;
(
    input wire logic link_clk,
    input wire logic rst_b,
    input wire logic enable_async,
    input wire logic nine_async,
    input wire logic data_in,
    output logic done_toggle,
    output rx_char_t hold0,
    output rx_char_t hold1
);

    // =============================================================
    // control crossing into the link domain
    logic en_s1_r;
    logic en_s2_r;
    logic nine_s1_r;
    logic nine_s2_r;
    logic [`SSR_NINE_BITS-1:0] shift_r;
    logic [3:0] count_r;

    wire [`SSR_NINE_BITS-1:0] shift_nxt = {data_in, shift_r[`SSR_NINE_BITS-1:1]};
    wire [3:0] need = nine_s2_r ? 4'h9 : 4'h8;
    wire last_bit = (count_r + 4'h1) == need;
    wire rx_char_t word = nine_s2_r ? rx_char_t'(shift_nxt)
                                    : rx_char_t'({1'b0, shift_nxt[`SSR_NINE_BITS-1:1]});

    always_ff @(negedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
            nine_s1_r <= 1'b0;
            nine_s2_r <= 1'b0;
        end else begin
            en_s1_r <= enable_async;
            en_s2_r <= en_s1_r;
            nine_s1_r <= nine_async;
            nine_s2_r <= nine_s1_r;
        end
    end

    // =============================================================
    // sample on the trailing edge, lsb first
    always_ff @(negedge link_clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_r <= `SSR_CHAR_RESET;
            count_r <= 4'h0;
            done_toggle <= 1'b0;
            hold0 <= rx_char_t'(`SSR_CHAR_RESET);
            hold1 <= rx_char_t'(`SSR_CHAR_RESET);
        end else if (!en_s2_r) begin
            count_r <= 4'h0;
        end else begin
            shift_r <= shift_nxt;
            if (last_bit) begin
                count_r <= 4'h0;
                // two slots so the system side has a full character to read
                if (done_toggle) begin
                    hold1 <= word;
                end else begin
                    hold0 <= word;
                end
                done_toggle <= ~done_toggle;
            end else begin
                count_r <= count_r + 4'h1;
            end
        end
    end

endmodule

// File: hdl/sync_serial_receiver.sv
// synchronous receive path: master clock generation, slave shifter,
// two-character receive fifo with overrun handling and 9-bit characters
// assumes software strobes are one sys_clk pulse; data pin synchronised here for the master path only
`timescale 1ns/1ps

module sync_serial_receiver
    import sync_serial_receiver_pkg::*;
#(
    parameter int HALF_CYCLES = `SSR_HALF_CYCLES,
    parameter int FIFO_DEPTH = `SSR_FIFO_DEPTH
)(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic transmit_clock_pin_in,
    input wire logic receive_data_pin_in,
    input wire logic serial_port_enable,
    input wire logic sync_mode_select,
    input wire logic clock_source_master_select,
    input wire logic nine_bit_receive_select,
    input wire logic single_receive_enable_set,
    input wire logic continuous_receive_enable,
    input wire logic receive_data_read,
    output logic receive_data_pin_out,
    output logic receive_data_pin_oe,
    output logic transmit_clock_pin_out,
    output logic transmit_clock_pin_oe,
    output logic single_receive_enable,
    output logic [`SSR_LOW_BITS-1:0] receive_data_register,
    output logic ninth_data_bit,
    output logic receive_available_flag,
    output logic overrun_error_flag
);

    localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int NW = $clog2(FIFO_DEPTH + 1);
    localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYCLES - 1);
    localparam logic [NW-1:0] FULL_COUNT = NW'(FIFO_DEPTH);
    localparam logic [PW-1:0] LAST_SLOT = PW'(FIFO_DEPTH - 1);

    // =============================================================
    // decoding
    function automatic logic [PW-1:0] next_slot(input logic [PW-1:0] p);
        next_slot = (p == LAST_SLOT) ? '0 : p + PW'(1);
    endfunction

    wire port_on = serial_port_enable && sync_mode_select;
    wire master = port_on && clock_source_master_select;
    wire slave = port_on && !clock_source_master_select;
    wire want_rx = single_receive_enable || continuous_receive_enable;
    wire [3:0] char_bits = nine_bit_receive_select ? 4'h9 : 4'h8;

    // =============================================================
    // data pin synchroniser for the master path
    logic din_s1_r;
    logic din_s2_r;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end else begin
            din_s1_r <= receive_data_pin_in;
            din_s2_r <= din_s1_r;
        end
    end

    // =============================================================
    // master clock generator and shifter
    master_state_t state_r;
    master_state_t state_nxt;
    logic [CW-1:0] div_r;
    logic [3:0] bits_r;
    logic [`SSR_NINE_BITS-1:0] shift_r;
    logic clk_out_r;
    // driven in the fifo section, read here to stop clocking on overrun
    logic overrun_set;

    wire div_done = (div_r == HALF_LAST);
    // no bit to hold on to once both enables are gone
    wire abort = !master || !want_rx;
    wire char_end = (state_r == ST_LOW) && div_done && (bits_r == char_bits);
    wire start_ok = master && want_rx && !overrun_error_flag;
    wire sample = (state_r == ST_HIGH) && div_done;
    wire [`SSR_NINE_BITS-1:0] shift_nxt = {din_s2_r, shift_r[`SSR_NINE_BITS-1:1]};
    wire rx_char_t master_char = nine_bit_receive_select ? rx_char_t'(shift_r)
                                 : rx_char_t'({1'b0, shift_r[`SSR_NINE_BITS-1:1]});
    wire master_done = char_end && !abort;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_ok) begin
                    state_nxt = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (abort) begin
                    state_nxt = ST_IDLE;
                end else if (div_done) begin
                    state_nxt = ST_LOW;
                end
            end
            ST_LOW: begin
                if (abort) begin
                    state_nxt = ST_IDLE;
                end else if (char_end) begin
                    // continuous keeps clocking back to back
                    if (continuous_receive_enable && !overrun_set) begin
                        state_nxt = ST_HIGH;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end else if (div_done) begin
                    state_nxt = ST_HIGH;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            div_r <= '0;
            bits_r <= 4'h0;
            shift_r <= `SSR_CHAR_RESET;
            clk_out_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            div_r <= (state_nxt != state_r) ? '0 : div_r + CW'(1);
            // leading edge rises, trailing edge falls
            clk_out_r <= (state_nxt == ST_HIGH);
            if (state_nxt == ST_IDLE || char_end) begin
                bits_r <= 4'h0;
            end else if (sample) begin
                bits_r <= bits_r + 4'h1;
                shift_r <= shift_nxt;
            end
        end
    end

    // =============================================================
    // slave path in the link clock domain
    logic slave_toggle;
    rx_char_t slave_hold0;
    rx_char_t slave_hold1;
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_s3_r;
    logic slave_en_r;

    link_shifter u_link_shifter (
        .link_clk(transmit_clock_pin_in),
        .rst_b(rst_b),
        .enable_async(slave_en_r),
        .nine_async(nine_bit_receive_select),
        .data_in(receive_data_pin_in),
        .done_toggle(slave_toggle),
        .hold0(slave_hold0),
        .hold1(slave_hold1)
    );

    // new toggle value v means the word sits in the other slot
    wire slave_event = (tog_s2_r != tog_s3_r);
    wire rx_char_t slave_char = tog_s2_r ? slave_hold0 : slave_hold1;
    wire slave_done = slave_event && slave && want_rx;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
            slave_en_r <= 1'b0;
        end else begin
            tog_s1_r <= slave_toggle;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
            slave_en_r <= slave && want_rx;
        end
    end

    // =============================================================
    // receive fifo
    rx_char_t fifo_mem [FIFO_DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [NW-1:0] count_r;
    logic overrun_error_flag_cont_r;

    wire push_req = master_done || slave_done;
    wire rx_char_t push_char = master_done ? master_char : slave_char;
    wire pop = receive_data_read && (count_r != '0);
    wire full = (count_r == FULL_COUNT);
    wire accept = push_req && !overrun_error_flag && (!full || pop);
    assign overrun_set = push_req && !overrun_error_flag && full && !pop;
    wire rx_char_t head = fifo_mem[rd_ptr_r];

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (!serial_port_enable) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (accept) begin
                wr_ptr_r <= next_slot(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= next_slot(rd_ptr_r);
            end
            if (accept && !pop) begin
                count_r <= count_r + NW'(1);
            end else if (pop && !accept) begin
                count_r <= count_r - NW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (accept) begin
            fifo_mem[wr_ptr_r] <= push_char;
        end
    end

    // =============================================================
    // overrun flag; a fresh set wins over the read and continuous-off clears, but not over port off
    wire overrun_error_flag_clear = !serial_port_enable
                      || (overrun_error_flag_cont_r && !continuous_receive_enable)
                      || (!overrun_error_flag_cont_r && receive_data_read);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            overrun_error_flag <= 1'b0;
            overrun_error_flag_cont_r <= 1'b0;
        end else if (overrun_set && serial_port_enable) begin
            overrun_error_flag <= 1'b1;
            overrun_error_flag_cont_r <= continuous_receive_enable;
        end else if (overrun_error_flag_clear) begin
            overrun_error_flag <= 1'b0;
            overrun_error_flag_cont_r <= 1'b0;
        end
    end

    // =============================================================
    // single-receive enable
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            single_receive_enable <= 1'b0;
        end else if (single_receive_enable_set && serial_port_enable) begin
            single_receive_enable <= 1'b1;
        end else if (!serial_port_enable || master_done || slave_done) begin
            single_receive_enable <= 1'b0;
        end
    end

    // =============================================================
    // registered outputs, one cycle behind the fifo state
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            receive_data_register <= '0;
            ninth_data_bit <= 1'b0;
            receive_available_flag <= 1'b0;
            receive_data_pin_out <= 1'b0;
            receive_data_pin_oe <= 1'b0;
            transmit_clock_pin_out <= 1'b0;
            transmit_clock_pin_oe <= 1'b0;
        end else begin
            receive_data_register <= (count_r != '0) ? head.low : '0;
            ninth_data_bit <= (count_r != '0) ? head.ninth : 1'b0;
            receive_available_flag <= (count_r != '0);
            receive_data_pin_out <= 1'b0;
            receive_data_pin_oe <= 1'b0;
            transmit_clock_pin_out <= clk_out_r;
            transmit_clock_pin_oe <= master;
        end
    end

endmodule

// File: sim/sync_serial_receiver_properties.sv
// checker for the synchronous receive path, bound to its top ports
// assumes one sys_clk domain and the constants header on the include path
`timescale 1ns/1ps
`include "sync_serial_receiver_regs.svh"

module sync_serial_receiver_properties (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic serial_port_enable,
    input wire logic sync_mode_select,
    input wire logic clock_source_master_select,
    input wire logic continuous_receive_enable,
    input wire logic receive_data_read,
    input wire logic receive_data_pin_oe,
    input wire logic transmit_clock_pin_out,
    input wire logic transmit_clock_pin_oe,
    input wire logic single_receive_enable,
    input wire logic [`SSR_LOW_BITS-1:0] receive_data_register,
    input wire logic ninth_data_bit,
    input wire logic receive_available_flag,
    input wire logic overrun_error_flag
);
    // =============================================================
    // properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    AST_DATA_PIN_QUIET: assert property (!receive_data_pin_oe)
        else $error("data pin driven");
    AST_SLAVE_NO_DRIVE: assert property (!clock_source_master_select [*2]
        |-> !transmit_clock_pin_oe) else $error("clock pin driven in slave mode");
    AST_MASTER_DRIVES: assert property ((serial_port_enable && sync_mode_select
        && clock_source_master_select) [*3] |-> transmit_clock_pin_oe)
        else $error("master clock pin not driven");
    AST_EMPTY_SHOWS_ZERO: assert property (!receive_available_flag
        |-> receive_data_register == 8'h00 && !ninth_data_bit)
        else $error("data shown with empty fifo");
    AST_OVERRUN_ON_FULL: assert property ($rose(overrun_error_flag)
        |-> receive_available_flag) else $error("overrun without stored data");
    AST_IDLE_NO_CLOCK: assert property ((!single_receive_enable
        && !continuous_receive_enable) [*6] |-> !transmit_clock_pin_out)
        else $error("clock runs with both enables low");
    AST_SINGLE_DONE_PUSH: assert property ($fell(single_receive_enable)
        && serial_port_enable |-> ##[0:4] (receive_available_flag || overrun_error_flag))
        else $error("single enable cleared without a character");
    AST_READ_CLEARS_OVR: assert property (overrun_error_flag && receive_data_read
        && !continuous_receive_enable |-> ##[1:3] !overrun_error_flag)
        else $error("read did not clear overrun");
    AST_CONT_CLEARS_OVR: assert property ($fell(continuous_receive_enable)
        && overrun_error_flag |-> ##[1:3] !overrun_error_flag)
        else $error("continuous off did not clear overrun");
    AST_PORT_OFF_RESETS: assert property (!serial_port_enable [*3]
        |-> !overrun_error_flag && !receive_available_flag && !single_receive_enable)
        else $error("port off left state behind");
endmodule

bind sync_serial_receiver sync_serial_receiver_properties chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .serial_port_enable(serial_port_enable),
    .sync_mode_select(sync_mode_select),
    .clock_source_master_select(clock_source_master_select),
    .continuous_receive_enable(continuous_receive_enable),
    .receive_data_read(receive_data_read), .receive_data_pin_oe(receive_data_pin_oe),
    .transmit_clock_pin_out(transmit_clock_pin_out),
    .transmit_clock_pin_oe(transmit_clock_pin_oe),
    .single_receive_enable(single_receive_enable),
    .receive_data_register(receive_data_register), .ninth_data_bit(ninth_data_bit),
    .receive_available_flag(receive_available_flag),
    .overrun_error_flag(overrun_error_flag)
);

// File: sim/serial_peer.sv
// far-side synchronous peer: feeds the data line, makes the link clock
// assumes the device clock idles low; bits go lsb first
`timescale 1ns/1ps

module serial_peer (
    input wire logic master_clk,
    output logic link_clk,
    output logic data
);
    // =============================================================
    // bit queue and drivers
    logic bq[$];

    initial begin
        link_clk = 1'b0;
        data = 1'b0;
    end

    // next bit on the leading edge; garbage when nothing is queued
    always @(posedge master_clk) begin
        if (bq.size() != 0)
            data <= bq.pop_front();
        else
            data <= ~data;
    end

    task automatic load(input logic [8:0] v, input int n);
        for (int i = 0; i < n; i++)
            bq.push_back(v[i]);
    endtask

    task automatic flush();
        bq.delete();
    endtask

    // only as many link clocks as bits; clock stands low between frames
    task automatic send(input logic [8:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            link_clk = 1'b1;
            data = v[i];
            #3 link_clk = 1'b0;
            #3;
        end
        data = ~data;
    endtask
endmodule

// File: sim/sync_serial_receiver_tb_top.sv
// bench: plays software and far side, checks against a queue model
// assumes HALF_CYCLES of 4 and a 6 ns link clock in slave mode
`timescale 1ns/1ps

module sync_serial_receiver_tb_top;
    import sync_serial_receiver_pkg::*;
    // =============================================================
    // stimulus and model state
    logic sys_clk = 1'b0, rst_b = 1'b0, en = 1'b0, sy = 1'b0, ms = 1'b0;
    logic nine = 1'b0, sset = 1'b0, cont = 1'b0, rd = 1'b0, ovm = 1'b0;
    logic ck_o, ck_oe, d_o, d_oe, sre, nd, av, ov, p_clk, p_dat, ck_pin, d_pin;
    logic [7:0] rdr;
    logic [8:0] q[$];
    int miscompares = 0, checks = 0, pulses = 0;

    assign ck_pin = ck_oe ? ck_o : p_clk;
    assign d_pin = d_oe ? d_o : p_dat;
    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge ck_o) pulses++;

    sync_serial_receiver #(.HALF_CYCLES(4)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .transmit_clock_pin_in(ck_pin),
        .receive_data_pin_in(d_pin), .serial_port_enable(en), .sync_mode_select(sy),
        .clock_source_master_select(ms), .nine_bit_receive_select(nine),
        .single_receive_enable_set(sset), .continuous_receive_enable(cont),
        .receive_data_read(rd), .receive_data_pin_out(d_o), .receive_data_pin_oe(d_oe),
        .transmit_clock_pin_out(ck_o), .transmit_clock_pin_oe(ck_oe),
        .single_receive_enable(sre), .receive_data_register(rdr), .ninth_data_bit(nd),
        .receive_available_flag(av), .overrun_error_flag(ov));
    serial_peer peer (.master_clk(ck_o), .link_clk(p_clk), .data(p_dat));

    // =============================================================
    // tasks
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic cmp(input string nm, input logic [8:0] e, input logic [8:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int n, input int tail);
        for (int i = 0; i < 3000 && pulses < n; i++)
            tick(1);
        tick(tail);
    endtask
    function automatic logic [8:0] rnd();
        return 9'($urandom) & (nine ? 9'h1FF : 9'h0FF);
    endfunction
    // ninth bit and low byte taken together, before the pop
    task automatic rd_one();
        logic [8:0] e;
        e = (q.size() != 0) ? q.pop_front() : 9'h000;
        cmp("char", e, {nd, rdr});
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(3);
        cmp("avail", 9'(q.size() != 0), 9'(av));
    endtask
    task automatic sgl();
        logic [8:0] v;
        v = rnd();
        peer.load(v, 8 + nine);
        if (q.size() < 2)
            q.push_back(v);
        else
            ovm = 1'b1;
        pulses = 0;
        sset = 1'b1;
        tick(1);
        sset = 1'b0;
        wt(8 + nine, 40);
        cmp("pulses", 9'(8 + nine), 9'(pulses));
        cmp("single_ovr", 9'({1'b0, ovm}), 9'({sre, ov}));
    endtask
    task automatic load3();
        logic [8:0] v;
        for (int k = 0; k < 3; k++) begin
            v = rnd();
            peer.load(v, 8);
            if (k < 2)
                q.push_back(v);
        end
        pulses = 0;
    endtask
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #1000000;
        miscompares++;
        test_done();
    end

    // =============================================================
    // tests
    initial begin
        logic [8:0] v;
        void'($urandom(33867));
        tick(16);
        rst_b = 1'b1;
        tick(2);
        cmp("reset", 9'h000, 9'({ov, av, sre, ck_oe, d_oe}));
        en = 1'b1; // no address detect input, so it stays off
        sy = 1'b1;
        ms = 1'b1;
        tick(4);
        cmp("pin_oe", 9'h001, 9'({d_o, d_oe, ck_oe}));
        for (int k = 0; k < 2; k++) begin
            nine = k[0];
            sgl();
            rd_one();
        end
        $display("test single done");
        nine = 1'b0;
        for (int k = 0; k < 3; k++) sgl();
        rd_one();
        cmp("ovr_read", 9'h000, 9'(ov));
        rd_one();
        ovm = 1'b0;
        for (int k = 0; k < 3; k++) sgl();
        en = 1'b0;
        tick(4);
        cmp("port_off", 9'h000, 9'({ov, av, sre}));
        q.delete();
        ovm = 1'b0;
        en = 1'b1;
        tick(3);
        $display("test single overrun done");
        load3();
        cont = 1'b1;
        wt(24, 60);
        cmp("cont_pulses", 9'h018, 9'(pulses));
        rd_one();
        rd_one();
        cmp("ovr_cont", 9'h001, 9'(ov));
        cont = 1'b0;
        tick(4);
        cmp("ovr_clear", 9'h000, 9'(ov));
        peer.flush();
        $display("test continuous done");
        load3();
        sset = 1'b1;
        cont = 1'b1;
        tick(1);
        sset = 1'b0;
        wt(19, 0);
        cont = 1'b0;
        tick(40);
        cmp("abort", 9'h013, 9'({sre, 8'(pulses)}));
        rd_one();
        rd_one();
        peer.flush();
        $display("test abort done");
        ms = 1'b0;
        cont = 1'b1;
        tick(4);
        cmp("slave_oe", 9'h000, 9'(ck_oe));
        // shifter enable crosses on the link clock, so two settling pulses first
        peer.send(9'h000, 2);
        tick(20);
        for (int k = 0; k < 2; k++) begin
            // second character in 9-bit form; the select settles within two link edges
            nine = k[0];
            v = rnd();
            peer.send(v, 8 + nine);
            q.push_back(v);
            tick(20);
        end
        cont = 1'b0;
        rd_one();
        rd_one();
        $display("test slave done");
        test_done();
    end
endmodule
